// ---- hdl/pm_cap_regs.sv ----
// Purpose: PM capability and inert message-IRQ capability, Avalon-MM slave
// Assumes: One clock, asynchronous active-low reset
// Notes:   Defaults preloaded by the sideband load port or bus registers
//
// Functional notes
// [RULE1] PM header reads ID 01h in low byte, next pointer in byte 1.
// [RULE2] PM next pointer resets to 8Ch.
// [RULE3] PM revision bits 18:16 read constant 011b.
// [RULE4] Event clock, B2/B3 and bus power control bits read zero.
// [RULE5] Device specific init bit 21 defaults to zero.
// [RULE6] Aux current bits 24:22 default 111b.
// [RULE7] D1 and D2 support bits default to one.
// [RULE8] Event support bits 31:27 default 11111b.
// [RULE9] Capability defaults overwritable at init by serial load or preload.
// [RULE10] Power state field 1:0 writable, resets to D0.
// [RULE11] D3hot to D0 write causes hot reset pulse.
// [RULE12] Skip-internal-reset defaults one; clear gives internal reset.
// [RULE13] Event enable bit 8 writable, reset 0, gates event messages.
// [RULE14] Event status bit 15 write-one-clear; reads 0 on enhanced function.
// [RULE15] Message capability ID reads 05h.
// [RULE16] Message next pointer resets to E0h.
// [RULE17] Message enable and count writable; capable fields zero; no messages.
// [RULE18] Message address 31:2 and data 16 bits stored, reset zero.
// [RULE19] Host clears pending status by writing one.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pm_cap_params.svh"

module pm_cap_regs #(
    parameter bit ENHANCED_FN = 1'b0
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire pm_cap_pkg::avmm_req_t     avm_req_i,
    output logic [31:0]                    avm_readdata_o,
    output logic                           avm_waitrequest_o,
    output logic [1:0]                     avm_response_o,
    input  wire logic                      preload_valid_i,
    input  wire pm_cap_pkg::cap_defaults_t preload_data_i,
    input  wire logic                      pm_event_i,
    output logic                           power_event_message_o,
    output logic                           hot_reset_o,
    output logic                           internal_reset_o,
    output logic [1:0]                     power_state_o,
    output logic                           irq_o
);
    import pm_cap_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cap_defaults_t dflt_q;
    power_state_t  pstate_q;
    logic          evt_en_q;
    logic [3:0]    dsel_q;
    logic          evt_sts_q;
    logic          msg_en_q;
    logic [2:0]    msg_mme_q;
    logic [29:0]   msg_addr_q;
    logic [15:0]   msg_data_q;
    logic [2:0]    irq_sts_q;
    logic [2:0]    irq_mask_q;
    logic          hot_reset_q;
    logic          int_reset_q;
    logic          pme_q;
    bus_state_t    bus_q;
    logic [31:0]   rdata_q;
    logic [1:0]    resp_q;
    logic          wr_go;
    logic          rd_go;
    logic          d3_exit;
    logic          mapped;
    logic [31:0]   rd_mux;
    logic [31:0]   wmask;

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, answer at second edge
    // ------------------------------------------------------------
    // Request is acted on only in the answer cycle, so a held request
    // is taken exactly once.
    assign wr_go = (bus_q == BUS_ACK) && avm_req_i.write;
    assign rd_go = (bus_q == BUS_ACK) && avm_req_i.read;
    assign wmask = {{8{avm_req_i.byteenable[3]}}, {8{avm_req_i.byteenable[2]}},
                    {8{avm_req_i.byteenable[1]}}, {8{avm_req_i.byteenable[0]}}};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_q <= BUS_IDLE;
        end else begin
            case (bus_q)
                BUS_IDLE: if (avm_req_i.read || avm_req_i.write) bus_q <= BUS_ACK;
                BUS_ACK:  bus_q <= BUS_IDLE;
                default:  bus_q <= BUS_IDLE;
            endcase
        end
    end

    assign avm_waitrequest_o = !(bus_q == BUS_ACK);

    // Address decode
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (avm_req_i.address)
            `OFS_PM_CAP: rd_mux = {dflt_q.evt_support, dflt_q.d2_support, // [RULE8] [RULE7]
                                   dflt_q.d1_support, dflt_q.aux_current,  // [RULE6]
                                   dflt_q.dev_init, 1'b0, 1'b0,            // [RULE5] [RULE4]
                                   `PM_REVISION,                           // [RULE3]
                                   dflt_q.pm_next, `PM_CAP_ID};            // [RULE1] [RULE2]
            `OFS_PM_CSR: rd_mux = {8'h00, 2'b00, 6'h00,                    // [RULE4]
                                   (ENHANCED_FN ? 1'b0 : evt_sts_q),       // [RULE14]
                                   2'b00, dsel_q, evt_en_q, 4'h0,
                                   dflt_q.no_soft_reset, 1'b0, pstate_q};  // [RULE12] [RULE10]
            `OFS_MSG_CTRL: rd_mux = {8'h00, 1'b0, msg_mme_q, 3'h0, msg_en_q, // [RULE17]
                                     dflt_q.msg_next, `MSG_CAP_ID};          // [RULE15] [RULE16]
            `OFS_MSG_ADDR: rd_mux = {msg_addr_q, 2'b00};                   // [RULE18]
            `OFS_MSG_DATA: rd_mux = {16'h0000, msg_data_q};                // [RULE18]
            `OFS_PRELOAD_CAP: rd_mux = {8'h00, dflt_q.pm_next, dflt_q.evt_support,
                                        dflt_q.d2_support, dflt_q.d1_support,
                                        dflt_q.aux_current, dflt_q.dev_init, 5'h00};
            `OFS_PRELOAD_MISC: rd_mux = {23'h0, dflt_q.no_soft_reset, dflt_q.msg_next};
            `OFS_IRQ_STATUS: rd_mux = {29'h0, irq_sts_q};
            `OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
            default: mapped = 1'b0;
        endcase
    end

    // Read data and response registered at the first edge, entering the answer cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h0000_0000;
            resp_q  <= 2'h0;
        end else if (bus_q == BUS_IDLE && (avm_req_i.read || avm_req_i.write)) begin
            rdata_q <= avm_req_i.read ? rd_mux : 32'h0000_0000;
            resp_q  <= mapped ? 2'h0 : 2'h2;
        end
    end

    assign avm_readdata_o = rdata_q;
    assign avm_response_o = resp_q;

    // ------------------------------------------------------------
    // Capability defaults: preload port, then bus preload registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dflt_q.pm_next       <= `PM_NEXT_RST;   // [RULE2]
            dflt_q.dev_init      <= `PM_DSI_RST;    // [RULE5]
            dflt_q.aux_current   <= `PM_AUX_RST;    // [RULE6]
            dflt_q.d1_support    <= `PM_D1_RST;     // [RULE7]
            dflt_q.d2_support    <= `PM_D2_RST;     // [RULE7]
            dflt_q.evt_support   <= `PM_EVT_SUP_RST; // [RULE8]
            dflt_q.no_soft_reset <= `PM_NO_SOFT_RST; // [RULE12]
            dflt_q.msg_next      <= `MSG_NEXT_RST;  // [RULE16]
        end else if (preload_valid_i) begin
            dflt_q <= preload_data_i;               // [RULE9]
        end else if (wr_go && avm_req_i.address == `OFS_PRELOAD_CAP) begin
            dflt_q.pm_next     <= avm_req_i.writedata[23:16]; // [RULE9]
            dflt_q.evt_support <= avm_req_i.writedata[15:11];
            dflt_q.d2_support  <= avm_req_i.writedata[10];
            dflt_q.d1_support  <= avm_req_i.writedata[9];
            dflt_q.aux_current <= avm_req_i.writedata[8:6];
            dflt_q.dev_init    <= avm_req_i.writedata[5];
        end else if (wr_go && avm_req_i.address == `OFS_PRELOAD_MISC) begin
            dflt_q.no_soft_reset <= avm_req_i.writedata[8]; // [RULE9]
            dflt_q.msg_next      <= avm_req_i.writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Power control / status
    // ------------------------------------------------------------
    assign d3_exit = wr_go && avm_req_i.address == `OFS_PM_CSR && avm_req_i.byteenable[0]
                     && pstate_q == PS_D3HOT && avm_req_i.writedata[1:0] == PS_D0;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pstate_q <= PS_D0;          // [RULE10]
            evt_en_q <= 1'b0;           // [RULE13]
            dsel_q   <= 4'h0;
        end else if (wr_go && avm_req_i.address == `OFS_PM_CSR) begin
            if (avm_req_i.byteenable[0]) begin
                pstate_q <= power_state_t'(avm_req_i.writedata[1:0]); // [RULE10]
            end
            if (avm_req_i.byteenable[1]) begin
                evt_en_q <= avm_req_i.writedata[`CSR_EVT_EN_BIT];     // [RULE13]
                dsel_q   <= avm_req_i.writedata[12:9];
            end
        end
    end

    // Event status: a new event wins over a same-cycle clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            evt_sts_q <= 1'b0;
        end else if (pm_event_i && !ENHANCED_FN) begin
            evt_sts_q <= 1'b1;          // [RULE14]
        end else if (wr_go && avm_req_i.address == `OFS_PM_CSR && avm_req_i.byteenable[1]
                     && avm_req_i.writedata[`CSR_EVT_STS_BIT]) begin
            evt_sts_q <= 1'b0;          // [RULE14] [RULE19]
        end
    end

    // Event message only while enabled; high one cycle after each cycle the event input is high
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pme_q <= 1'b0;
        end else begin
            pme_q <= pm_event_i && evt_en_q && !ENHANCED_FN; // [RULE13]
        end
    end
    assign power_event_message_o = pme_q;

    // Reset pulses on D3hot to D0 exit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hot_reset_q <= 1'b0;
            int_reset_q <= 1'b0;
        end else begin
            hot_reset_q <= d3_exit;                          // [RULE11]
            int_reset_q <= d3_exit && !dflt_q.no_soft_reset; // [RULE12]
        end
    end
    assign hot_reset_o      = hot_reset_q;
    assign internal_reset_o = int_reset_q;
    assign power_state_o    = pstate_q;

    // ------------------------------------------------------------
    // Inert message-interrupt registers: stored, never used
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            msg_en_q   <= 1'b0;         // [RULE17]
            msg_mme_q  <= 3'h0;
            msg_addr_q <= 30'h0000_0000; // [RULE18]
            msg_data_q <= 16'h0000;
        end else if (wr_go) begin
            if (avm_req_i.address == `OFS_MSG_CTRL && avm_req_i.byteenable[2]) begin
                msg_en_q  <= avm_req_i.writedata[`MCTL_EN_BIT];  // [RULE17]
                msg_mme_q <= avm_req_i.writedata[22:20];
            end
            if (avm_req_i.address == `OFS_MSG_ADDR) begin
                msg_addr_q <= (avm_req_i.writedata[31:2] & wmask[31:2]) // [RULE18]
                              | (msg_addr_q & ~wmask[31:2]);
            end
            if (avm_req_i.address == `OFS_MSG_DATA) begin
                msg_data_q <= (avm_req_i.writedata[15:0] & wmask[15:0])
                              | (msg_data_q & ~wmask[15:0]);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts: bit0 event, bit1 hot reset, bit2 internal reset
    // ------------------------------------------------------------
    // Set beats a same-cycle read-to-clear; an event in the read's wait cycle is cleared unread.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_sts_q  <= 3'h0;
            irq_mask_q <= 3'h0;
        end else begin
            irq_sts_q <= ((rd_go && avm_req_i.address == `OFS_IRQ_STATUS) ? 3'h0 : irq_sts_q)
                         | {int_reset_q, hot_reset_q, pm_event_i};
            if (wr_go && avm_req_i.address == `OFS_IRQ_MASK) begin
                irq_mask_q <= avm_req_i.writedata[2:0];
            end
        end
    end
    assign irq_o = |(irq_sts_q & irq_mask_q);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rst_d0;
        @(posedge clk_i) disable iff (!reset_n_i) $rose(reset_n_i) |-> pstate_q == PS_D0;
    endproperty
    a_rst_d0: assert property (p_rst_d0) else $error("state not D0"); // [RULE10]

    // Hot reset is a single-cycle pulse after the exit write

    sequence s_d3_exit;
        d3_exit;
    endsequence
    property p_hot_reset;
        @(posedge clk_i) disable iff (!reset_n_i) s_d3_exit |=> hot_reset_o ##1 !hot_reset_o;
    endproperty
    a_hot_reset: assert property (p_hot_reset) else $error("no hot reset pulse"); // [RULE11]


    property p_int_reset;
        @(posedge clk_i) disable iff (!reset_n_i)
            internal_reset_o |-> hot_reset_o && !$past(dflt_q.no_soft_reset);
    endproperty
    a_int_reset: assert property (p_int_reset) else $error("bad internal reset"); // [RULE12]


    property p_pme_gate;
        @(posedge clk_i) disable iff (!reset_n_i) power_event_message_o |-> $past(evt_en_q);
    endproperty
    a_pme_gate: assert property (p_pme_gate) else $error("event sent while off"); // [RULE13]


    property p_sts_sticky;
        @(posedge clk_i) disable iff (!reset_n_i)
            pm_event_i && !ENHANCED_FN |=> evt_sts_q;
    endproperty
    a_sts_sticky: assert property (p_sts_sticky) else $error("status not set"); // [RULE14]

    // Read data of a header word stands one edge after the answer

    property p_pm_hdr;
        @(posedge clk_i) disable iff (!reset_n_i)
            rd_go && avm_req_i.address == `OFS_PM_CAP |=>
            avm_readdata_o[7:0] == 8'h01 && avm_readdata_o[18:16] == 3'h3
            && avm_readdata_o[20:19] == 2'h0;
    endproperty
    a_pm_hdr: assert property (p_pm_hdr) else $error("PM header wrong"); // [RULE1]


    property p_msg_hdr;
        @(posedge clk_i) disable iff (!reset_n_i)
            rd_go && avm_req_i.address == `OFS_MSG_CTRL |=>
            avm_readdata_o[7:0] == 8'h05 && avm_readdata_o[19:17] == 3'h0
            && !avm_readdata_o[23];
    endproperty
    a_msg_hdr: assert property (p_msg_hdr) else $error("message header wrong"); // [RULE15]


    property p_addr_low;
        @(posedge clk_i) disable iff (!reset_n_i)
            rd_go && avm_req_i.address == `OFS_MSG_ADDR |=> avm_readdata_o[1:0] == 2'h0;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low bits set"); // [RULE18]


    property p_one_wait;
        @(posedge clk_i) disable iff (!reset_n_i)
            bus_q == BUS_IDLE && (avm_req_i.read || avm_req_i.write)
            |-> avm_waitrequest_o ##1 !avm_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer late");

    // Enhanced function never shows pending status
    property p_sts_enh;
        @(posedge clk_i) disable iff (!reset_n_i)
            rd_go && avm_req_i.address == `OFS_PM_CSR && ENHANCED_FN
            |=> !avm_readdata_o[`CSR_EVT_STS_BIT];
    endproperty
    a_sts_enh: assert property (p_sts_enh) else $error("enhanced status set"); // [RULE14]

    // Cleared skip bit must give the internal reset, not only allow it
    property p_int_rst_on;
        @(posedge clk_i) disable iff (!reset_n_i)
            d3_exit && !dflt_q.no_soft_reset |=> internal_reset_o;
    endproperty
    a_int_rst_on: assert property (p_int_rst_on) else $error("no internal reset"); // [RULE12]

endmodule

// ---- hdl/pm_cap_params.svh ----
// Purpose: Offsets, field positions, reset values for the PM / message-IRQ block
// Assumes: 32-bit word registers on the Avalon-MM slave
// Notes:   Included by the design module only
`ifndef PM_CAP_PARAMS_SVH
`define PM_CAP_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_PM_CAP        8'h80
`define OFS_PM_CSR        8'h84
`define OFS_MSG_CTRL      8'h8C
`define OFS_MSG_ADDR      8'h90
`define OFS_MSG_DATA      8'h94
`define OFS_PRELOAD_CAP   8'hC0
`define OFS_PRELOAD_MISC  8'hC4
`define OFS_IRQ_STATUS    8'hC8
`define OFS_IRQ_MASK      8'hCC

// ------------------------------------------------------------
// Constants and reset values
// ------------------------------------------------------------
`define PM_CAP_ID         8'h01
`define PM_NEXT_RST       8'h8C
`define PM_REVISION       3'h3
`define PM_DSI_RST        1'h0
`define PM_AUX_RST        3'h7
`define PM_D1_RST         1'h1
`define PM_D2_RST         1'h1
`define PM_EVT_SUP_RST    5'h1F
`define PM_NO_SOFT_RST    1'h1
`define MSG_CAP_ID        8'h05
`define MSG_NEXT_RST      8'hE0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CSR_STATE_LSB     0
`define CSR_NSR_BIT       3
`define CSR_EVT_EN_BIT    8
`define CSR_DSEL_LSB      9
`define CSR_EVT_STS_BIT   15
`define MCTL_EN_BIT       16
`define MCTL_MME_LSB      20

`endif

// ---- hdl/pm_cap_pkg.sv ----
// Purpose: Types for the PM / message-IRQ register block
// Assumes: Nothing beyond the params header
// Notes:   Constants live in pm_cap_params.svh
package pm_cap_pkg;

    // Power state encoding
    typedef enum logic [1:0] {
        PS_D0     = 2'h0,
        PS_D1     = 2'h1,
        PS_D2     = 2'h2,
        PS_D3HOT  = 2'h3
    } power_state_t;

    // Preloadable defaults of the capability words
    typedef struct packed {
        logic [7:0] pm_next;
        logic       dev_init;
        logic [2:0] aux_current;
        logic       d1_support;
        logic       d2_support;
        logic [4:0] evt_support;
        logic       no_soft_reset;
        logic [7:0] msg_next;
    } cap_defaults_t;

    // Avalon-MM request bundle
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avmm_req_t;

    // Read and write sequencing state of the bus slave
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage

// ---- tb/pm_cfg_host_model.sv ----
// Purpose: Host-side model issuing register requests over Avalon-MM
// Assumes: Slave answers by dropping waitrequest, no fixed latency assumed
// Notes:   Blocking task; the bench watchdog ends a hung wait
`timescale 1ns/1ps

module pm_cfg_host_model (
    input  wire logic              clk_i,
    output pm_cap_pkg::avmm_req_t  req_o,
    input  wire logic [31:0]       readdata_i,
    input  wire logic              waitrequest_i,
    input  wire logic [1:0]        response_i
);
    import pm_cap_pkg::*;

    // ------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------
    // Idle at time zero so no request appears during reset
    initial begin
        req_o = '0;
    end

    // One access, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] r);
        @(posedge clk_i);
        req_o <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
        // Pre-edge values: answer and read data taken at the same edge
        do begin
            @(posedge clk_i);
        end while (waitrequest_i !== 1'b0);
        q = readdata_i;
        r = response_i;
        // Idle lines inverted so a stale address is never read as live
        req_o <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d, byteenable: 4'h0};
    endtask
endmodule

// ---- tb/pcie_pm_msi_capability_regs_tb_top.sv ----
// Purpose: Self-checking bench for the PM and message-IRQ register block
// Assumes: Host model drives the register bus of both function kinds
// Notes:   Pulse outputs are counted every edge to catch stray pulses
`timescale 1ns/1ps

module pcie_pm_msi_capability_regs_tb_top;
    import pm_cap_pkg::*;

    logic          clk_i;
    logic          reset_n_i;
    avmm_req_t     avm_req;
    logic [31:0]   rdata;
    logic [31:0]   rdata_e;
    logic          wait_rq;
    logic [1:0]    resp;
    logic          preload_valid;
    cap_defaults_t preload_data;
    logic          pm_event;
    logic          evt_msg;
    logic          hot_rst;
    logic          int_rst;
    logic [1:0]    pstate;
    logic          irq;
    int            errors = 0;
    int            checked = 0;
    int            ev_cnt = 0;
    int            hr_cnt = 0;
    int            ir_cnt = 0;

    // ------------------------------------------------------------
    // Clock, instances, pulse counters
    // ------------------------------------------------------------
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    pm_cap_regs #(.ENHANCED_FN(1'b0)) dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .avm_req_i(avm_req),
        .avm_readdata_o(rdata), .avm_waitrequest_o(wait_rq), .avm_response_o(resp),
        .preload_valid_i(preload_valid), .preload_data_i(preload_data),
        .pm_event_i(pm_event), .power_event_message_o(evt_msg), .hot_reset_o(hot_rst),
        .internal_reset_o(int_rst), .power_state_o(pstate), .irq_o(irq));

    pm_cfg_host_model host_u (
        .clk_i(clk_i), .req_o(avm_req), .readdata_i(rdata),
        .waitrequest_i(wait_rq), .response_i(resp));

    // Enhanced function shares the bus; only its read data is watched
    pm_cap_regs #(.ENHANCED_FN(1'b1)) enh_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .avm_req_i(avm_req),
        .avm_readdata_o(rdata_e), .avm_waitrequest_o(), .avm_response_o(),
        .preload_valid_i(preload_valid), .preload_data_i(preload_data),
        .pm_event_i(pm_event), .power_event_message_o(), .hot_reset_o(),
        .internal_reset_o(), .power_state_o(), .irq_o());

    // Counting catches a pulse that is longer or repeated
    always @(posedge clk_i) begin
        if (evt_msg === 1'b1) ev_cnt++;
        if (hot_rst === 1'b1) hr_cnt++;
        if (int_rst === 1'b1) ir_cnt++;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
        logic [31:0] q;
        logic [1:0]  r;
        host_u.xfer(1'b0, a, 32'h0, q, r);
        chk($sformatf("read %h", a), exp, q);
        chk($sformatf("response %h", a), {30'h0, er}, {30'h0, r});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0]  r;
        host_u.xfer(1'b1, a, d, q, r);
    endtask

    task automatic do_reset();
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask

    // Event pulse; message expected in the cycle after it is sampled
    task automatic pulse(input logic exp_msg);
        @(posedge clk_i);
        pm_event <= 1'b1;
        @(posedge clk_i);
        pm_event <= 1'b0;
        #1;
        chk("event message", {31'h0, exp_msg}, {31'h0, evt_msg});
        repeat (2) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        rd(8'h80, 32'hFFC38C01);
        rd(8'h84, 32'h00000008);
        rd(8'h8C, 32'h0000E005);
        rd(8'h90, 32'h0);
        rd(8'h94, 32'h0);
        rd(8'hCC, 32'h0);
        chk("power state port", 32'h0, {30'h0, pstate});
        $display("test defaults done");
    endtask

    // All-ones writes show which bits are writable
    task automatic t_writes();
        wr(8'h80, 32'hFFFFFFFF);
        rd(8'h80, 32'hFFC38C01);
        wr(8'h8C, 32'hFFFFFFFF);
        rd(8'h8C, 32'h0071E005);
        wr(8'h90, 32'hFFFFFFFF);
        rd(8'h90, 32'hFFFFFFFC);
        wr(8'h94, 32'hFFFFFFFF);
        rd(8'h94, 32'h0000FFFF);
        wr(8'h84, 32'hFFFFFFFF);
        rd(8'h84, 32'h00001F0B);
        $display("test writes done");
    endtask

    // Only the D3hot to D0 step may give a hot reset
    task automatic t_power();
        logic [1:0] seq [6];
        int         h0;
        int         i0;
        seq = '{2'd1, 2'd2, 2'd3, 2'd0, 2'd1, 2'd0};
        h0 = hr_cnt;
        i0 = ir_cnt;
        foreach (seq[i]) begin
            wr(8'h84, {30'h0, seq[i]});
            #1;
            chk("hot reset", {31'h0, i == 3}, {31'h0, hot_rst});
            rd(8'h84, {28'h0, 1'b1, 1'b0, seq[i]});
            chk("power state port", {30'h0, seq[i]}, {30'h0, pstate});
        end
        chk("hot reset count", h0 + 1, hr_cnt);
        chk("internal reset count", i0, ir_cnt);
        $display("test power done");
    endtask

    task automatic t_event();
        int e0;
        e0 = ev_cnt;
        rd(8'hC8, 32'h2);
        pulse(1'b0);
        chk("event count off", e0, ev_cnt);
        rd(8'h84, 32'h00008008);
        chk("enhanced status", 32'h00000008, rdata_e);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'hCC, 32'h1);
        #1;
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(8'hC8, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(8'h84, 32'h00000100);
        pulse(1'b1);
        chk("event count on", e0 + 1, ev_cnt);
        chk("irq again", 32'h1, {31'h0, irq});
        wr(8'h84, 32'h00008100);
        rd(8'h84, 32'h00000108);
        rd(8'hC8, 32'h1);
        $display("test event done");
    endtask

    task automatic t_unmapped();
        rd(8'h40, 32'h0, 2'b10);
        wr(8'h98, 32'hFFFFFFFF);
        rd(8'h98, 32'h0, 2'b10);
        $display("test unmapped done");
    endtask

    // Preloaded defaults replace the read-only capability fields
    task automatic t_preload();
        int i0;
        @(posedge clk_i);
        preload_data <= '{pm_next: 8'hA4, dev_init: 1'b1, aux_current: 3'h2, d1_support: 1'b0,
                          d2_support: 1'b1, evt_support: 5'h0A, no_soft_reset: 1'b0,
                          msg_next: 8'h5C};
        preload_valid <= 1'b1;
        @(posedge clk_i);
        preload_valid <= 1'b0;
        rd(8'h80, {5'h0A, 1'b1, 1'b0, 3'h2, 1'b1, 2'b00, 3'h3, 8'hA4, 8'h01});
        rd(8'h8C, 32'h00005C05);
        rd(8'h84, 32'h0);
        i0 = ir_cnt;
        wr(8'h84, 32'h3);
        wr(8'h84, 32'h0);
        #1;
        chk("internal reset", 32'h1, {31'h0, int_rst});
        repeat (2) @(posedge clk_i);
        chk("internal reset count", i0 + 1, ir_cnt);
        rd(8'hC8, 32'h6);
        rd(8'hC0, 32'h00A454A0);
        $display("test preload done");
    endtask

    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0;
        preload_valid = 1'b0;
        preload_data = '0;
        pm_event = 1'b0;
        do_reset();
        t_defaults();
        t_writes();
        t_power();
        t_event();
        t_unmapped();
        do_reset();
        t_defaults();
        t_preload();
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk_i);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        close_out();
    end
endmodule
